// >>> rtl/ack_agility_auto_repeater.sv
// Ack channel and rate agility plus auto-repeat decision logic with its control register.
`timescale 1ns/1ns
module ack_agility_auto_repeater
    import ack_repeat_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire logic        i_clk_en,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_rx_done,
    input  wire logic [1:0]  i_frame_type,
    input  wire logic        i_ack_request_flag,
    input  wire logic        i_frame_repeat_request,
    input  wire logic        i_broadcast,
    input  wire logic [63:0] i_dest_addr,
    input  wire logic [7:0]  i_ack_info_octet,
    input  wire logic [1:0]  i_seen_count,
    input  wire logic [1:0]  i_trx_mode,
    input  wire logic [63:0] i_own_long_addr,
    input  wire logic [3:0]  i_channel_select,
    input  wire logic [3:0]  i_rate_select,
    input  wire logic        i_tx_done,
    output logic      [7:0]  o_reg_rdata,
    output logic             o_ack_start,
    output logic             o_repeat_start,
    output logic             o_deliver,
    output logic      [3:0]  o_tx_channel,
    output logic      [3:0]  o_tx_rate
);

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] rdata_q, rdata_d;
    logic       hit;
    logic       eligible_type, to_me, streaming, too_many, repeat_ok;

    assign hit = (i_reg_addr == RX_CONTROL_TWO_ADDR);

    always_comb begin
        ctrl_d  = ctrl_q;
        rdata_d = rdata_q;
        if (i_reg_wr && hit) begin
            ctrl_d[6:0] = i_reg_wdata[6:0] & RX_CONTROL_TWO_WMASK[6:0];
            // Buffer-full is clearable only by writing one.
            if (i_reg_wdata[BIT_RECEIVE_BUFFER_FULL]) begin
                ctrl_d[BIT_RECEIVE_BUFFER_FULL] = 1'b0;
            end
        end
        // Hardware set wins over a simultaneous software clear only for a frame that is repeated.
        if (i_rx_done && (repeat_ok || !ctrl_q[BIT_RECEIVE_BUFFER_FULL])) begin
            ctrl_d[BIT_RECEIVE_BUFFER_FULL] = 1'b1;
        end
        if (i_reg_rd) begin
            rdata_d = hit ? ctrl_q : 8'h00;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ctrl_q  <= RX_CONTROL_TWO_RESET;
            rdata_q <= 8'h00;
        end else if (i_clk_en) begin
            ctrl_q  <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Repeat decision
    // ------------------------------------------------------------------
    // data and command
    assign eligible_type = (i_frame_type == FRAME_TYPE_DATA) || (i_frame_type == FRAME_TYPE_COMMAND);
    assign to_me     = !i_broadcast && (i_dest_addr == i_own_long_addr);
    assign streaming = (i_trx_mode == MODE_RX_STREAM) || (i_trx_mode == MODE_TX_STREAM);
    assign too_many  = ctrl_q[BIT_DUPLICATE_REJECT] && (i_seen_count > SEEN_LIMIT);
    assign repeat_ok = ctrl_q[BIT_REPEATER_ENABLE] && i_frame_repeat_request && eligible_type
                       && !to_me && !streaming && !too_many;

    // ------------------------------------------------------------------
    // Ack and repeat sequencing
    // ------------------------------------------------------------------
    logic       ack_start_q, ack_start_d;
    logic       rpt_start_q, rpt_start_d;
    logic       deliver_q, deliver_d;
    logic       ack_busy_q, ack_busy_d;
    logic [7:0] info_q, info_d;
    logic [3:0] chan_q, chan_d;
    logic [3:0] rate_q, rate_d;
    logic [3:0] sel_chan, sel_rate;

    ack_tune_select u_tune (
        .i_ack_active     (ack_busy_d),
        .i_chan_follow    (ctrl_q[BIT_ACK_CHANNEL_FOLLOW]),
        .i_rate_follow    (ctrl_q[BIT_ACK_RATE_FOLLOW]),
        .i_ack_info       (info_d),
        .i_channel_select (i_channel_select),
        .i_rate_select    (i_rate_select),
        .o_channel        (sel_chan),
        .o_rate           (sel_rate)
    );

    always_comb begin
        ack_start_d = 1'b0;
        rpt_start_d = 1'b0;
        deliver_d   = 1'b0;
        ack_busy_d  = ack_busy_q;
        info_d      = info_q;
        if (i_tx_done) begin
            ack_busy_d = 1'b0;
        end
        if (i_rx_done && !streaming) begin
            if (repeat_ok) begin
                rpt_start_d = 1'b1;
            end else begin
                deliver_d = 1'b1;
                if (ctrl_q[BIT_AUTO_ACK_ENABLE] && i_ack_request_flag) begin
                    ack_start_d = 1'b1;
                    ack_busy_d  = 1'b1;
                    info_d      = i_ack_info_octet;
                end
            end
        end
        chan_d = sel_chan;
        rate_d = sel_rate;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ack_start_q <= 1'b0;
            rpt_start_q <= 1'b0;
            deliver_q   <= 1'b0;
            ack_busy_q  <= 1'b0;
            info_q      <= 8'h00;
            chan_q      <= 4'h0;
            rate_q      <= 4'h0;
        end else if (i_clk_en) begin
            ack_start_q <= ack_start_d;
            rpt_start_q <= rpt_start_d;
            deliver_q   <= deliver_d;
            ack_busy_q  <= ack_busy_d;
            info_q      <= info_d;
            chan_q      <= chan_d;
            rate_q      <= rate_d;
        end
    end

    assign o_reg_rdata    = rdata_q;
    assign o_ack_start    = ack_start_q;
    assign o_repeat_start = rpt_start_q;
    assign o_deliver      = deliver_q;
    assign o_tx_channel   = chan_q;
    assign o_tx_rate      = rate_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_ack_channel_follow: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (i_clk_en && o_ack_start && ctrl_q[BIT_ACK_CHANNEL_FOLLOW] && $stable(ctrl_q[BIT_ACK_CHANNEL_FOLLOW]))
        |-> o_tx_channel == info_q[ACK_CHANNEL_LSB +: 4])
        else $error("Ack channel not taken from ack info.");
    a_ack_rate_follow: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (o_ack_start && ctrl_q[BIT_ACK_RATE_FOLLOW] && $stable(ctrl_q[BIT_ACK_RATE_FOLLOW]))
        |-> o_tx_rate == info_q[ACK_RATE_LSB +: 4])
        else $error("Ack rate not taken from ack info.");
    a_no_stream_repeat: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (i_clk_en && streaming) |=> !o_repeat_start)
        else $error("Repeat started in streaming mode.");
    a_repeat_type_only: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (i_clk_en && i_rx_done && !eligible_type) |=> !o_repeat_start)
        else $error("Non data or command frame repeated.");
    a_own_not_repeated: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (i_clk_en && i_rx_done && to_me && !streaming) |=> (o_deliver && !o_repeat_start))
        else $error("Own unicast frame was repeated.");
    a_repeat_issued: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (i_clk_en && i_rx_done && repeat_ok) |=> o_repeat_start)
        else $error("Eligible frame not repeated.");
    a_dup_limit: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (i_clk_en && i_rx_done && too_many) |=> !o_repeat_start)
        else $error("Duplicate beyond limit repeated.");
    a_auto_ack_now: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (i_clk_en && i_rx_done && !streaming && !repeat_ok && i_ack_request_flag
         && ctrl_q[BIT_AUTO_ACK_ENABLE]) |=> o_ack_start)
        else $error("Auto ack not started after reception.");
    a_tune_restore: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (i_clk_en && !ack_busy_d) |=> (o_tx_channel == $past(i_channel_select)))
        else $error("Channel not restored after ack.");

endmodule : ack_agility_auto_repeater

// >>> shared/ack_repeat_pkg.sv
// Package with register map, field positions and encodings for the ack agility and auto-repeater block.
package ack_repeat_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] RX_CONTROL_TWO_ADDR  = 8'h16;
    localparam logic [7:0] RX_CONTROL_TWO_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Field positions of receive_control_two
    // ------------------------------------------------------------------
    localparam int BIT_RECEIVE_BUFFER_FULL = 7;
    localparam int BIT_DUPLICATE_REJECT    = 6;
    localparam int BIT_REPEATER_ENABLE     = 3;
    localparam int BIT_AUTO_ACK_ENABLE     = 2;
    localparam int BIT_ACK_CHANNEL_FOLLOW  = 1;
    localparam int BIT_ACK_RATE_FOLLOW     = 0;
    localparam logic [7:0] RX_CONTROL_TWO_WMASK = 8'h7F;

    // ------------------------------------------------------------------
    // Ack info octet layout and frame types
    // ------------------------------------------------------------------
    localparam int ACK_CHANNEL_LSB = 4;
    localparam int ACK_RATE_LSB    = 0;
    localparam logic [1:0] FRAME_TYPE_DATA    = 2'h1;
    localparam logic [1:0] FRAME_TYPE_COMMAND = 2'h3;
    localparam logic [1:0] SEEN_LIMIT         = 2'h2;

    typedef enum logic [1:0] {
        MODE_PACKET,
        MODE_RX_STREAM,
        MODE_TX_STREAM
    } trx_mode_t;

endpackage : ack_repeat_pkg

// >>> rtl/ack_tune_select.sv
// Picks channel and rate for the next transmission from ack info or configuration.
`timescale 1ns/1ns
module ack_tune_select
    import ack_repeat_pkg::*;
(
    input  wire logic       i_ack_active,
    input  wire logic       i_chan_follow,
    input  wire logic       i_rate_follow,
    input  wire logic [7:0] i_ack_info,
    input  wire logic [3:0] i_channel_select,
    input  wire logic [3:0] i_rate_select,
    output logic      [3:0] o_channel,
    output logic      [3:0] o_rate
);

    always_comb begin
        o_channel = i_channel_select;
        o_rate    = i_rate_select;
        if (i_ack_active && i_chan_follow) begin
            o_channel = i_ack_info[ACK_CHANNEL_LSB +: 4];
        end
        if (i_ack_active && i_rate_follow) begin
            o_rate = i_ack_info[ACK_RATE_LSB +: 4];
        end
    end

endmodule : ack_tune_select

// >>> verif/peer_tx_model.sv
// Peer side model that reports the end of each automatic transmission.
`timescale 1ns/1ns
module peer_tx_model (
    input  wire logic       i_mclk,
    input  wire logic       i_tx_start,
    input  wire logic [3:0] i_delay,
    output logic            o_tx_done
);
    logic       busy_q = 1'b0;
    logic [3:0] cnt_q  = 4'h0;
    initial o_tx_done = 1'b0;
    // channel access delay
    // The delay stands in for CSMA/CA backoff, so both prompt and slow air access get exercised.
    always @(negedge i_mclk) begin
        o_tx_done <= 1'b0;
        if (busy_q) begin
            if (cnt_q == 4'h0) begin
                o_tx_done <= 1'b1;
                busy_q    <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 4'h1;
            end
        end else if (i_tx_start) begin
            busy_q <= 1'b1;
            cnt_q  <= i_delay;
        end
    end
endmodule : peer_tx_model

// >>> verif/testbench.sv
// Self-checking bench for the ack agility and auto-repeat block.
`timescale 1ns/1ns
module testbench;
    import ack_repeat_pkg::*;
    logic        mclk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, rx_done = 0, ack_req = 0, rpt_req = 0, bcast = 0;
    logic        tx_done, rep_o, del_o, ack_o;
    logic        clk_en = 1;
    logic [7:0]  addr = 8'h16, wdata = 8'h00, info = 8'h00, rdata, rd_v;
    logic [1:0]  ftype = 2'h1, seen = 2'h1, mode = 2'h0;
    logic [63:0] dest = 64'h0, own = 64'h0123_4567_89AB_CDEF;
    logic [3:0]  ch_cfg = 4'hA, rt_cfg = 4'h3, delay = 4'h0, tx_ch, tx_rt, ch_v, rt_v;
    logic [2:0]  got;
    int          err_count = 0, total_checks = 0;

    always #20 mclk = ~mclk;

    ack_agility_auto_repeater ack_agility_auto_repeater_inst (.i_mclk(mclk), .i_reset_n(reset_n),
        .i_clk_en(clk_en), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_rx_done(rx_done), .i_frame_type(ftype), .i_ack_request_flag(ack_req), .i_frame_repeat_request(rpt_req),
        .i_broadcast(bcast), .i_dest_addr(dest), .i_ack_info_octet(info), .i_seen_count(seen), .i_trx_mode(mode),
        .i_own_long_addr(own), .i_channel_select(ch_cfg), .i_rate_select(rt_cfg), .i_tx_done(tx_done),
        .o_reg_rdata(rdata), .o_ack_start(ack_o), .o_repeat_start(rep_o), .o_deliver(del_o),
        .o_tx_channel(tx_ch), .o_tx_rate(tx_rt));

    peer_tx_model peer_tx_model_inst (.i_mclk(mclk), .i_tx_start(ack_o | rep_o), .i_delay(delay),
        .o_tx_done(tx_done));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic check(input string name, input logic [7:0] seen_v, input logic [7:0] exp_v);
        total_checks++;
        if (seen_v !== exp_v) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp_v, seen_v);
        end
    endtask : check

    task automatic reg_access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_wr = wr;
        reg_rd = !wr;
        addr   = a;
        wdata  = d;
        @(negedge mclk);
        reg_wr = 0;
        reg_rd = 0;
        rd_v   = rdata;
    endtask : reg_access

    // Sends one parsed frame, captures the answer and waits for any started transmission to end.
    task automatic frame(input logic [1:0] t, input logic r, input logic b, input logic [63:0] d,
                         input logic [1:0] s, input logic [1:0] m);
        @(negedge mclk);
        {ftype, rpt_req, bcast, dest, seen, mode, rx_done} = {t, r, b, d, s, m, 1'b1};
        @(negedge mclk);
        rx_done = 0;
        got     = {rep_o, del_o, ack_o};
        {ch_v, rt_v} = {tx_ch, tx_rt};
        if (got[2] | got[0]) begin
            for (int i = 0; i < 20 && tx_done !== 1'b1; i++) @(posedge mclk);
            if (tx_done !== 1'b1) begin
                err_count++;
                report_and_stop();
            end
            @(negedge mclk);
            check("tuning_back", {tx_ch, tx_rt}, {ch_cfg, rt_cfg});
        end
    endtask : frame

    task automatic regs_scenario();
        reg_access(0, 8'h16, 8'h00);
        check("reset_value", rd_v, RX_CONTROL_TWO_RESET);
        reg_access(1, 8'h16, 8'hFF);
        reg_access(0, 8'h16, 8'h00);
        check("write_back", rd_v, 8'h7F);
        reg_access(1, 8'h17, 8'h00);
        reg_access(0, 8'h16, 8'h00);
        check("unmapped_write", rd_v & 8'h03, 8'h03);
        reg_access(0, 8'h20, 8'h00);
        check("unmapped_read", rd_v, 8'h00);
    endtask : regs_scenario

    task automatic agility_scenario();
        ack_req = 1;
        info = 8'h75;
        for (int en = 0; en < 4; en++) begin
            reg_access(1, 8'h16, 8'h04 | en[7:0]);
            delay = en[3:0] * 4'h3;
            frame(FRAME_TYPE_DATA, 0, 0, own, 2'h1, 2'h0);
            check("ack_deliver", {5'h0, got}, 8'h03);
            check("ack_channel", {4'h0, ch_v}, en[1] ? 8'h07 : 8'h0A);
            check("ack_rate", {4'h0, rt_v}, en[0] ? 8'h05 : 8'h03);
        end
        reg_access(1, 8'h16, 8'h03);
        frame(FRAME_TYPE_DATA, 0, 0, own, 2'h1, 2'h0);
        check("no_auto_ack", {5'h0, got}, 8'h02);
        ack_req = 0;
    endtask : agility_scenario

    task automatic repeat_scenario();
        reg_access(1, 8'h16, 8'h08);
        for (int t = 0; t < 4; t++) begin
            frame(t[1:0], 1, 1, 64'h0, 2'h1, 2'h0);
            check("type_filter", {5'h0, got}, (t == 1 || t == 3) ? 8'h04 : 8'h02);
        end
        frame(FRAME_TYPE_COMMAND, 1, 0, own, 2'h1, 2'h0);
        check("own_unicast", {5'h0, got}, 8'h02);
        frame(FRAME_TYPE_DATA, 1, 0, ~own, 2'h1, 2'h0);
        check("foreign_unicast", {5'h0, got}, 8'h04);
        frame(FRAME_TYPE_DATA, 0, 1, 64'h0, 2'h1, 2'h0);
        check("no_request", {5'h0, got}, 8'h02);
        for (int m = 1; m < 3; m++) begin
            frame(FRAME_TYPE_DATA, 1, 1, 64'h0, 2'h1, m[1:0]);
            check("streaming", {5'h0, got}, 8'h00);
        end
        reg_access(1, 8'h16, 8'h48);
        frame(FRAME_TYPE_DATA, 1, 1, 64'h0, 2'h2, 2'h0);
        check("seen_twice", {5'h0, got}, 8'h04);
        frame(FRAME_TYPE_DATA, 1, 1, 64'h0, 2'h3, 2'h0);
        check("seen_thrice", {5'h0, got}, 8'h02);
        reg_access(1, 8'h16, 8'h00);
        frame(FRAME_TYPE_DATA, 1, 1, 64'h0, 2'h1, 2'h0);
        check("repeater_off", {5'h0, got}, 8'h02);
        // Buffer-full was set by the receptions above and is cleared by writing one.
        reg_access(0, 8'h16, 8'h00);
        check("buffer_full_set", rd_v, 8'h80);
        reg_access(1, 8'h16, 8'h80);
        reg_access(0, 8'h16, 8'h00);
        check("buffer_full_clear", rd_v, 8'h00);
    endtask : repeat_scenario

    // With the clock enable low neither a frame nor a register write may leave a trace.
    task automatic freeze_scenario();
        reg_access(1, 8'h16, 8'h08);
        clk_en = 0;
        frame(FRAME_TYPE_DATA, 1, 1, 64'h0, 2'h1, 2'h0);
        check("frozen_frame", {5'h0, got}, 8'h00);
        reg_access(1, 8'h16, 8'h00);
        clk_en = 1;
        reg_access(0, 8'h16, 8'h00);
        check("frozen_register", rd_v, 8'h08);
    endtask : freeze_scenario

    initial begin
        repeat (2) @(negedge mclk);
        reset_n = 1;
        regs_scenario();
        agility_scenario();
        repeat_scenario();
        freeze_scenario();
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        report_and_stop();
    end
endmodule : testbench
